// file: rtl/ipfb_bank.sv
// Function
// RULE1 - Each maskable source gets its own priority setting output.
// RULE2 - Level combines same-position bits from low-order and high-order register sets.
// RULE3 - Registers accept bit or byte writes; bit writes leave other bits alone.
// RULE4 - Group 0..2 low/high byte pairs take one halfword write; group 3 not.
// RULE5 - Reset loads every priority register with all ones, lowest level.
// RULE6 - Each register write stalls the CPU for two extra clocks.
// RULE7 - Software keeps unassigned bits at one.
// RULE8 - Pair 00 is level 0 highest, 01 level 1, 10 level 2, 11 level 3.
// RULE9 - Unassigned bits read as one and never give a priority decode.
`timescale 1ns/10ps
`default_nettype none
module ipfb_bank
	import ipfb_pkg::*;
(
	input wire logic clk_in, // 250 MHz system clock
	input wire logic rst_b_in, // Synchronous reset, active low
	input wire logic ce_in, // Clock enable, freezes all state
	input wire ipfb_req_t bus_in, // CPU access request
	output logic [15:0] rdata_out, // Read data, registered
	output logic rvalid_out, // Read data valid pulse
	output logic stall_out, // CPU wait after a write
	output logic [IPFB_NSRC-1:0][1:0] level_out // Priority level per source
);
	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic [IPFB_NREG-1:0][7:0] reg_r;
	logic [IPFB_NREG-1:0][7:0] reg_nxt;
	logic [IPFB_NREG-1:0] hit_vec;
	logic [1:0] stall_cnt_r;
	logic [1:0] stall_cnt_nxt;
	logic [15:0] rdata_nxt;
	logic [15:0] rd_word;
	wire any_hit = |hit_vec;
	wire is_half = bus_in.size == IPFB_SZ_HALF;
	wire is_bit = bus_in.size == IPFB_SZ_BIT;
	wire is_narrow = is_bit | (bus_in.size == IPFB_SZ_BYTE);
	// Writes while stalled are dropped; the CPU is held anyway
	wire wr_ok = ce_in & bus_in.wr & ~stall_out & any_hit;
	wire rd_ok = ce_in & bus_in.rd & ~bus_in.wr;
	genvar gi;
	generate
		for (gi = 0; gi < IPFB_NREG; gi++) begin : g_reg
			localparam int SLOT = gi % IPFB_NSLOT;
			localparam logic [7:0] MASK = IPFB_UNUSED_MASK[SLOT];
			logic [7:0] bit_val;
			logic [7:0] wval;
			logic sel_narrow;
			logic sel_half_lo;
			logic sel_half_hi;
			assign hit_vec[gi] = bus_in.addr == IPFB_REG_ADDR[gi];
			assign sel_narrow = wr_ok & is_narrow & hit_vec[gi]; // [RULE3]
			// Halfword only at the low address of a real pair
			assign sel_half_lo = wr_ok & is_half & hit_vec[gi] & IPFB_PAIR_LO_SLOT[SLOT]; // [RULE4]
			if (IPFB_PAIR_HI_SLOT[SLOT]) begin : g_hi
				assign sel_half_hi = wr_ok & is_half & hit_vec[gi-1]; // [RULE4]
			end else begin : g_nohi
				assign sel_half_hi = 1'b0;
			end
			assign bit_val = (8'h01 << bus_in.bit_idx);
			assign wval = is_bit ?
				(bus_in.wdata[0] ? (reg_r[gi] | bit_val) : (reg_r[gi] & ~bit_val)) : // [RULE3]
				bus_in.wdata[7:0];
			// Unassigned bits are stuck at one regardless of data
			assign reg_nxt[gi] = (sel_narrow | sel_half_lo) ? (wval | MASK) : // [RULE9]
				sel_half_hi ? (bus_in.wdata[15:8] | MASK) : reg_r[gi];
			always_ff @(posedge clk_in) begin
				if (!rst_b_in) begin
					reg_r[gi] <= IPFB_RESET_VAL; // [RULE5]
				end else if (ce_in) begin
					reg_r[gi] <= reg_nxt[gi];
				end
			end
		end
		// -----------------------------------------------------------
		// Level outputs
		// -----------------------------------------------------------
		for (gi = 0; gi < IPFB_NSRC; gi++) begin : g_lvl
			// High set bit is the level msb; 11 is the lowest level
			always_ff @(posedge clk_in) begin
				if (!rst_b_in) begin
					level_out[gi] <= IPFB_LEVEL_RESET; // [RULE5]
				end else if (ce_in) begin
					level_out[gi] <= {reg_nxt[IPFB_NSLOT + gi/8][gi%8],
						reg_nxt[gi/8][gi%8]}; // [RULE1] [RULE2] [RULE8]
				end
			end
		end
	endgenerate
	// ---------------------------------------------------------------
	// Read path and write stall
	// ---------------------------------------------------------------
	always_comb begin
		rd_word = 16'h0000;
		for (int i = 0; i < IPFB_NREG; i++) begin
			if (hit_vec[i]) begin
				rd_word[7:0] = reg_r[i];
			end
		end
		// Upper byte walks from index 1 so no select runs past the bank
		for (int i = 1; i < IPFB_NREG; i++) begin
			if (hit_vec[i-1] && is_half && IPFB_PAIR_LO_SLOT[(i-1) % IPFB_NSLOT]) begin
				rd_word[15:8] = reg_r[i];
			end
		end
	end
	assign rdata_nxt = rd_ok ? rd_word : rdata_out;
	assign stall_cnt_nxt = wr_ok ? IPFB_WR_EXTRA_CLK : // [RULE6]
		((stall_cnt_r != 2'h0) ? (stall_cnt_r - 2'h1) : 2'h0);
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			stall_cnt_r <= 2'h0;
			stall_out <= 1'b0;
			rdata_out <= 16'h0000;
			rvalid_out <= 1'b0;
		end else if (ce_in) begin
			stall_cnt_r <= stall_cnt_nxt;
			stall_out <= stall_cnt_nxt != 2'h0; // [RULE6]
			rdata_out <= rdata_nxt;
			rvalid_out <= rd_ok;
		end
	end
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_reset_ones;
		@(posedge clk_in) !rst_b_in |=> (reg_r[0] == IPFB_RESET_VAL) && (level_out[0] == 2'h3);
	endproperty
	a_reset_ones: assert property (p_reset_ones) else $error("reset value wrong"); // [RULE5]
	property p_stall_two;
		@(posedge clk_in) disable iff (!rst_b_in || !ce_in)
			wr_ok |=> stall_out [*2] ##1 !stall_out;
	endproperty
	a_stall_two: assert property (p_stall_two) else $error("write stall not two clocks"); // [RULE6]
	property p_byte_write;
		@(posedge clk_in) disable iff (!rst_b_in)
			(wr_ok && bus_in.size == IPFB_SZ_BYTE && hit_vec[2])
			|=> reg_r[2] == ($past(bus_in.wdata[7:0]) | IPFB_UNUSED_MASK[2]);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write lost"); // [RULE3]
	property p_bit_keep;
		@(posedge clk_in) disable iff (!rst_b_in)
			(wr_ok && is_bit && hit_vec[0])
			|=> (reg_r[0] & ~(8'h01 << $past(bus_in.bit_idx)))
			== ($past(reg_r[0]) & ~(8'h01 << $past(bus_in.bit_idx)));
	endproperty
	a_bit_keep: assert property (p_bit_keep) else $error("bit write disturbed others"); // [RULE3]
	property p_half_pair;
		@(posedge clk_in) disable iff (!rst_b_in)
			(wr_ok && is_half && hit_vec[9])
			|=> reg_r[10] == ($past(bus_in.wdata[15:8]) | IPFB_UNUSED_MASK[3]);
	endproperty
	a_half_pair: assert property (p_half_pair) else $error("halfword high byte lost"); // [RULE4]
	property p_group3_nohalf;
		@(posedge clk_in) disable iff (!rst_b_in)
			(ce_in && bus_in.wr && is_half && hit_vec[6]) |=> $stable(reg_r[6]);
	endproperty
	a_group3_nohalf: assert property (p_group3_nohalf) else $error("group 3 took halfword"); // [RULE4]
	property p_unused_one;
		@(posedge clk_in) disable iff (!rst_b_in)
			##1 ((reg_r[13] & IPFB_UNUSED_MASK[6]) == IPFB_UNUSED_MASK[6])
			&& (level_out[6*8] == 2'h3);
	endproperty
	a_unused_one: assert property (p_unused_one) else $error("unused bit not one"); // [RULE9]
	property p_level_decode;
		@(posedge clk_in) disable iff (!rst_b_in || !ce_in)
			##1 level_out[2] == {reg_r[IPFB_NSLOT][2], reg_r[0][2]};
	endproperty
	a_level_decode: assert property (p_level_decode) else $error("level decode wrong"); // [RULE2] [RULE8]
	property p_busy_drop;
		@(posedge clk_in) disable iff (!rst_b_in)
			(stall_out && bus_in.wr && hit_vec[3]) |=> $stable(reg_r[3]);
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("write taken while stalled"); // [RULE6]
	property p_bit_set;
		@(posedge clk_in) disable iff (!rst_b_in)
			(wr_ok && is_bit && hit_vec[0]) |=> reg_r[0][$past(bus_in.bit_idx)] == $past(bus_in.wdata[0]);
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit write value lost"); // [RULE3]
	property p_half_lo;
		@(posedge clk_in) disable iff (!rst_b_in)
			(wr_ok && is_half && hit_vec[9]) |=> reg_r[9] == ($past(bus_in.wdata[7:0]) | IPFB_UNUSED_MASK[2]);
	endproperty
	a_half_lo: assert property (p_half_lo) else $error("halfword low byte lost"); // [RULE4]
	property p_half_read;
		@(posedge clk_in) disable iff (!rst_b_in)
			(rd_ok && is_half && hit_vec[9]) |=> rdata_out == {$past(reg_r[10]), $past(reg_r[9])};
	endproperty
	a_half_read: assert property (p_half_read) else $error("halfword read wrong"); // [RULE4]
	property p_half_odd;
		@(posedge clk_in) disable iff (!rst_b_in)
			(wr_ok && is_half && hit_vec[1]) |=> $stable(reg_r[1]) && $stable(reg_r[0]);
	endproperty
	a_half_odd: assert property (p_half_odd) else $error("halfword at high byte taken"); // [RULE4]
	property p_group3_high;
		@(posedge clk_in) disable iff (!rst_b_in)
			(ce_in && bus_in.wr && is_half && hit_vec[13]) |=> $stable(reg_r[13]);
	endproperty
	a_group3_high: assert property (p_group3_high) else $error("group 3 high took halfword"); // [RULE4]
	property p_nohit_nostall;
		@(posedge clk_in) disable iff (!rst_b_in)
			(ce_in && bus_in.wr && !any_hit && !stall_out) |=> !stall_out;
	endproperty
	a_nohit_nostall: assert property (p_nohit_nostall) else $error("unmapped write stalled"); // [RULE6]
	property p_ce_hold;
		@(posedge clk_in) disable iff (!rst_b_in)
			!ce_in |=> $stable(reg_r) && $stable(stall_out) && $stable(level_out);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved while disabled"); // [RULE6]
	property p_reset_clear;
		@(posedge clk_in)
			!rst_b_in |=> !stall_out && !rvalid_out && (level_out[IPFB_NSRC-1] == IPFB_LEVEL_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind"); // [RULE5]
	property p_read_g3;
		@(posedge clk_in) disable iff (!rst_b_in)
			(rd_ok && hit_vec[13]) |=> (rdata_out[7:0] & IPFB_UNUSED_MASK[6]) == IPFB_UNUSED_MASK[6];
	endproperty
	a_read_g3: assert property (p_read_g3) else $error("unused bit read as zero"); // [RULE9]
	// ---------------------------------------------------------------
	// Coverage
	// ---------------------------------------------------------------
	c_half_write: cover property (@(posedge clk_in) wr_ok && is_half);
	c_bit_write: cover property (@(posedge clk_in) wr_ok && is_bit);
	c_level0: cover property (@(posedge clk_in) level_out[0] == 2'h0);
	c_read: cover property (@(posedge clk_in) rvalid_out && rdata_out[15:8] != 8'h00);
	c_busy_write: cover property (@(posedge clk_in) stall_out && bus_in.wr && any_hit);
endmodule
`default_nettype wire

// file: common/ipfb_pkg.sv
`default_nettype none
package ipfb_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int IPFB_NSLOT = 7;
	localparam int IPFB_NREG = 14;
	localparam int IPFB_NSRC = 56;
	localparam logic [7:0] IPFB_RESET_VAL = 8'hFF;
	localparam logic [1:0] IPFB_LEVEL_RESET = 2'h3;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP0_LO = 20'hFFFE8;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP0_HI = 20'hFFFE9;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP1_LO = 20'hFFFEA;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP1_HI = 20'hFFFEB;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP2_LO = 20'hFFFD8;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP2_HI = 20'hFFFD9;
	localparam logic [19:0] IPFB_PRIO_LOW_GROUP3 = 20'hFFFDA;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP0_LO = 20'hFFFEC;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP0_HI = 20'hFFFED;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP1_LO = 20'hFFFEE;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP1_HI = 20'hFFFEF;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP2_LO = 20'hFFFDC;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP2_HI = 20'hFFFDD;
	localparam logic [19:0] IPFB_PRIO_HIGH_GROUP3 = 20'hFFFDE;
	// Index = set * 7 + slot; slots g0L g0H g1L g1H g2L g2H g3
	localparam logic [IPFB_NREG-1:0][19:0] IPFB_REG_ADDR = {
		IPFB_PRIO_HIGH_GROUP3, IPFB_PRIO_HIGH_GROUP2_HI, IPFB_PRIO_HIGH_GROUP2_LO,
		IPFB_PRIO_HIGH_GROUP1_HI, IPFB_PRIO_HIGH_GROUP1_LO, IPFB_PRIO_HIGH_GROUP0_HI,
		IPFB_PRIO_HIGH_GROUP0_LO,
		IPFB_PRIO_LOW_GROUP3, IPFB_PRIO_LOW_GROUP2_HI, IPFB_PRIO_LOW_GROUP2_LO,
		IPFB_PRIO_LOW_GROUP1_HI, IPFB_PRIO_LOW_GROUP1_LO, IPFB_PRIO_LOW_GROUP0_HI,
		IPFB_PRIO_LOW_GROUP0_LO};
	// Bits with no source, per slot; held at one
	localparam logic [IPFB_NSLOT-1:0][7:0] IPFB_UNUSED_MASK = {
		8'hE3, 8'hA0, 8'h20, 8'hE0, 8'h00, 8'h18, 8'h00};
	// Slots that are the high byte of a 16-bit pair
	localparam logic [IPFB_NSLOT-1:0] IPFB_PAIR_HI_SLOT = 7'h2A;
	localparam logic [IPFB_NSLOT-1:0] IPFB_PAIR_LO_SLOT = 7'h15;
	// ---------------------------------------------------------------
	// Access and timing
	// ---------------------------------------------------------------
	localparam logic [1:0] IPFB_WR_EXTRA_CLK = 2'h2;
	typedef enum logic [1:0] {
		IPFB_SZ_BIT = 2'b00,
		IPFB_SZ_BYTE = 2'b01,
		IPFB_SZ_HALF = 2'b10,
		IPFB_SZ_RSVD = 2'b11
	} ipfb_size_t;
	typedef struct packed {
		logic wr;
		logic rd;
		ipfb_size_t size;
		logic [2:0] bit_idx;
		logic [19:0] addr;
		logic [15:0] wdata;
	} ipfb_req_t;
endpackage
`default_nettype wire

// file: sim/ipfb_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module ipfb_cpu_model
	import ipfb_pkg::*;
(
	input wire logic clk_in, // System clock
	input wire logic [15:0] rdata_in, // Read data from the bank
	input wire logic rvalid_in, // Read data valid
	output var ipfb_req_t bus_out // Request to the bank
);
	initial bus_out = '0;
	// Idle lines flip so a stale address never looks valid
	task automatic idle();
		bus_out = '{wr: 1'b0, rd: 1'b0, size: bus_out.size, bit_idx: bus_out.bit_idx,
			addr: ~bus_out.addr, wdata: ~bus_out.wdata};
	endtask
	task automatic write(input logic [19:0] a, input ipfb_size_t sz, input logic [2:0] bi,
		input logic [15:0] d);
		@(posedge clk_in);
		#1;
		bus_out = '{wr: 1'b1, rd: 1'b0, size: sz, bit_idx: bi, addr: a, wdata: d};
		@(posedge clk_in);
		#1;
		idle();
	endtask
	task automatic read(input logic [19:0] a, input ipfb_size_t sz, output logic [15:0] d);
		@(posedge clk_in);
		#1;
		bus_out = '{wr: 1'b0, rd: 1'b1, size: sz, bit_idx: 3'h0, addr: a, wdata: 16'h0000};
		@(posedge clk_in);
		#1;
		d = rvalid_in ? rdata_in : 16'hXXXX;
		idle();
	endtask
endmodule
`default_nettype wire

// file: sim/interrupt_priority_flag_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_flag_bank_test;
	import ipfb_pkg::*;
	logic clk_in;
	logic rst_b_in;
	logic ce_in;
	ipfb_req_t bus;
	logic [15:0] rdata;
	logic rvalid;
	logic stall;
	logic [IPFB_NSRC-1:0][1:0] level;
	logic [IPFB_NREG-1:0][7:0] expv;
	logic [15:0] rd_v;
	int fails;
	int total_checks;
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	ipfb_bank dut(.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .bus_in(bus),
		.rdata_out(rdata), .rvalid_out(rvalid), .stall_out(stall), .level_out(level));
	ipfb_cpu_model cpu(.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .bus_out(bus));
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [111:0] got, input logic [111:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [111:0] lvl_exp();
		logic [111:0] v;
		for (int s = 0; s < IPFB_NSLOT; s++)
			for (int b = 0; b < 8; b++)
				v[(s*8+b)*2 +: 2] = {expv[IPFB_NSLOT+s][b], expv[s][b]};
		return v;
	endfunction
	task automatic wr(input logic [19:0] a, input ipfb_size_t sz, input logic [2:0] bi,
		input logic [15:0] d, input logic st);
		cpu.write(a, sz, bi, d);
		chk(112'(stall), 112'(st));
		@(posedge clk_in);
		#1;
		chk(112'(stall), 112'(st));
		@(posedge clk_in);
		#1;
		chk(112'(stall), 112'(1'b0));
	endtask
	task automatic rdc(input logic [19:0] a, input ipfb_size_t sz, input logic [15:0] e);
		cpu.read(a, sz, rd_v);
		chk(112'(rd_v), 112'(e));
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		end_of_test();
	end
	initial begin
		fails = 0;
		total_checks = 0;
		ce_in = 1'b1;
		rst_b_in = 1'b0;
		repeat (8) @(posedge clk_in);
		#1;
		rst_b_in = 1'b1;
		for (int i = 0; i < IPFB_NREG; i++) begin
			expv[i] = IPFB_RESET_VAL;
			rdc(IPFB_REG_ADDR[i], IPFB_SZ_BYTE, {8'h00, expv[i]});
		end
		chk(level, lvl_exp());
		$display("reset test done");
		// Low 55 and high 33 give all four level codes
		for (int i = 0; i < IPFB_NREG; i++) begin
			expv[i] = (i < IPFB_NSLOT ? 8'h55 : 8'h33) | IPFB_UNUSED_MASK[i % IPFB_NSLOT];
			wr(IPFB_REG_ADDR[i], IPFB_SZ_BYTE, 3'h0, {8'h00, expv[i]}, 1'b1);
			chk(level, lvl_exp());
			rdc(IPFB_REG_ADDR[i], IPFB_SZ_BYTE, {8'h00, expv[i]});
		end
		$display("byte test done");
		wr(IPFB_PRIO_LOW_GROUP0_LO, IPFB_SZ_BIT, 3'h7, 16'h0001, 1'b1);
		wr(IPFB_PRIO_LOW_GROUP0_LO, IPFB_SZ_BIT, 3'h0, 16'h0000, 1'b1);
		expv[0] = 8'hD4;
		rdc(IPFB_PRIO_LOW_GROUP0_LO, IPFB_SZ_BYTE, 16'h00D4);
		chk(level, lvl_exp());
		$display("bit test done");
		// Second write lands inside the stall and must be dropped
		cpu.write(IPFB_PRIO_LOW_GROUP1_HI, IPFB_SZ_BYTE, 3'h0, 16'h00F0);
		cpu.write(IPFB_PRIO_LOW_GROUP1_HI, IPFB_SZ_BYTE, 3'h0, 16'h0000);
		expv[3] = 8'hF0;
		rdc(IPFB_PRIO_LOW_GROUP1_HI, IPFB_SZ_BYTE, 16'h00F0);
		chk(level, lvl_exp());
		$display("busy test done");
		wr(IPFB_PRIO_HIGH_GROUP1_LO, IPFB_SZ_HALF, 3'h0, 16'h1234, 1'b1);
		expv[9] = 8'h34;
		expv[10] = 8'hF2;
		rdc(IPFB_PRIO_HIGH_GROUP1_LO, IPFB_SZ_HALF, 16'hF234);
		wr(IPFB_PRIO_LOW_GROUP0_HI, IPFB_SZ_HALF, 3'h0, 16'h0000, 1'b1);
		rdc(IPFB_PRIO_LOW_GROUP0_LO, IPFB_SZ_HALF, {expv[1], expv[0]});
		wr(IPFB_PRIO_LOW_GROUP3, IPFB_SZ_HALF, 3'h0, 16'h0000, 1'b1);
		rdc(IPFB_PRIO_LOW_GROUP3, IPFB_SZ_BYTE, {8'h00, expv[6]});
		chk(level, lvl_exp());
		$display("halfword test done");
		// Zeros on unassigned bits must not stick
		wr(IPFB_PRIO_HIGH_GROUP3, IPFB_SZ_BYTE, 3'h0, 16'h0000, 1'b1);
		expv[13] = IPFB_UNUSED_MASK[6];
		rdc(IPFB_PRIO_HIGH_GROUP3, IPFB_SZ_BYTE, {8'h00, expv[13]});
		chk(level, lvl_exp());
		wr(IPFB_PRIO_HIGH_GROUP3, IPFB_SZ_HALF, 3'h0, 16'h0000, 1'b1);
		rdc(IPFB_PRIO_HIGH_GROUP3, IPFB_SZ_BYTE, {8'h00, expv[13]});
		wr(20'hFFFDB, IPFB_SZ_BYTE, 3'h0, 16'h0000, 1'b0);
		$display("unassigned test done");
		// Write with the enable low must leave everything as it was
		@(posedge clk_in);
		#1;
		ce_in = 1'b0;
		cpu.write(IPFB_PRIO_HIGH_GROUP0_LO, IPFB_SZ_BYTE, 3'h0, 16'h0000);
		ce_in = 1'b1;
		chk(112'(stall), 112'(1'b0));
		rdc(IPFB_PRIO_HIGH_GROUP0_LO, IPFB_SZ_BYTE, {8'h00, expv[7]});
		chk(level, lvl_exp());
		$display("enable test done");
		@(posedge clk_in);
		#1;
		rst_b_in = 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
		rst_b_in = 1'b1;
		for (int i = 0; i < IPFB_NREG; i++)
			expv[i] = IPFB_RESET_VAL;
		chk(level, lvl_exp());
		rdc(IPFB_PRIO_HIGH_GROUP1_LO, IPFB_SZ_HALF, 16'hFFFF);
		$display("second reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
